// ===== verif/hld_pipe_model.sv
/*
  Issue-pipeline model that drives divides and result reads.
  Assumes one core clock; the bench calls issue and sets want_rd.
*/
`timescale 1ns/100ps
module hld_pipe_model
  import hld_pkg::*;
(
  input  wire logic clk,
  input  wire logic want_rd,
  output logic      req_valid,
  output hld_req_t  req,
  output logic      move_from_upper_result,
  output logic      move_from_lower_result
);
  // ---------------------------------------------------------------------------
  // Issue and reads
  // ---------------------------------------------------------------------------
  initial begin
    req_valid              = 1'b0;
    req                    = '0;
    move_from_upper_result = 1'b0;
    move_from_lower_result = 1'b0;
  end
  always @(posedge clk) begin
    move_from_upper_result <= want_rd;
    move_from_lower_result <= want_rd;
  end
  task automatic issue(input hld_op_t op, input logic [63:0] a, input logic [63:0] b);
    @(posedge clk);
    req_valid <= 1'b1;
    req       <= '{op, a, b};
    @(posedge clk);
    req_valid <= 1'b0;
    req       <= ~req;
  endtask : issue
endmodule : hld_pipe_model

// ===== verif/test_hilo_integer_divider.sv
/*
  Self-checking bench for the divide unit against an integer model.
  Assumes the pipeline model drives all request and read inputs.
*/
`timescale 1ns/100ps
module test_hilo_integer_divider;
  import hld_pkg::*;
  logic        clk, sys_rst, want_rd, req_valid, busy, read_stall, busy_r6, rsv_r6;
  logic        arith_exception, reserved_instruction;
  logic        move_from_upper_result, move_from_lower_result;
  logic [63:0] ra, rb;
  hld_req_t    req;
  hld_res_t    res, prev;
  int          err_count = 0, total_checks = 0, cyc = 0, n;
  integer      seed = 32'h27DE;
  // ---------------------------------------------------------------------------
  // Instances, clock, timeout
  // ---------------------------------------------------------------------------
  hld_pipe_model i_hld_pipe_model (.clk, .want_rd, .req_valid, .req,
    .move_from_upper_result, .move_from_lower_result);
  hld_divider i_hld_divider (.clk, .sys_rst, .req_valid, .req, .move_from_upper_result,
    .move_from_lower_result, .busy, .read_stall, .arith_exception, .reserved_instruction, .res);
  hld_divider #(.RELEASE(4'h6)) i_hld_divider_r6 (.clk, .sys_rst, .req_valid, .req,
    .move_from_upper_result, .move_from_lower_result, .busy(busy_r6), .read_stall(),
    .arith_exception(), .reserved_instruction(rsv_r6), .res());
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up
  function automatic hld_res_t ref_div(hld_op_t op, logic [63:0] a, logic [63:0] b);
    longint   sa, sb, q, r;
    hld_res_t e;
    sa = (op == HLD_OP_WORD_SIGNED) ? longint'(signed'(a[31:0])) : a;
    sb = (op == HLD_OP_WORD_SIGNED) ? longint'(signed'(b[31:0])) : b;
    q = sa / sb;
    r = sa % sb;
    e = '{r, q};
    if (op == HLD_OP_WORD_SIGNED) e.lower_result_register = longint'(signed'(q[31:0]));
    if (op == HLD_OP_DWORD_UNSIGN) e = '{a % b, a / b};
    return e;
  endfunction : ref_div
  // ---------------------------------------------------------------------------
  // One divide with timing and result checks
  // ---------------------------------------------------------------------------
  task automatic run(input hld_op_t op, input logic [63:0] a, input logic [63:0] b, input bit cr);
    hld_res_t e;
    if (cr) e = ref_div(op, a, b);
    prev = res;
    i_hld_pipe_model.issue(op, a, b);
    #1;
    chk("r6_rsv", 1, rsv_r6);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      want_rd = (n == 2);
      if (n == 1) chk("held_hi", prev[127:64], res[127:64]);
      if (n == 1) chk("held_lo", prev[63:0], res[63:0]);
      if (n == 1) chk("r6_busy", 0, busy_r6);
      chk("rsv", 0, reserved_instruction);
      if (n == 4) chk("stall", 1, read_stall);
      chk("exc", 0, arith_exception);
    end while (busy !== 1'b0 && n < 100);
    chk("lat", (op == HLD_OP_WORD_SIGNED) ? 33 : 65, n);
    chk("stall_end", 0, read_stall);
    if (cr) chk("upper", e.upper_result_register, res.upper_result_register);
    if (cr) chk("lower", e.lower_result_register, res.lower_result_register);
  endtask : run
  initial begin
    sys_rst = 1'b1;
    want_rd = 1'b0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("rst_res", 0, res.lower_result_register);
    chk("rst_busy", 0, busy);
    chk("rst_stall", 0, read_stall);
    $display("reset test done");
    run(HLD_OP_WORD_SIGNED, 64'hFFFF_FFFF_FFFF_FFF9, 64'h2, 1);
    run(HLD_OP_WORD_SIGNED, 64'hABCD_0000_0000_0007, 64'h1234_5678_FFFF_FFFE, 1);
    run(HLD_OP_WORD_SIGNED, 64'h8000_0000, 64'hFFFF_FFFF, 1);
    run(HLD_OP_DWORD_SIGNED, 64'hFFFF_FFFF_FFFF_FFF9, 64'h2, 1);
    run(HLD_OP_DWORD_SIGNED, 64'h8000_0000_0000_0000, 64'h3, 1);
    run(HLD_OP_DWORD_UNSIGN, 64'hFFFF_FFFF_FFFF_FFFF, 64'h1, 1);
    run(HLD_OP_DWORD_UNSIGN, 64'h5, 64'h8000_0000_0000_0007, 1);
    $display("directed test done");
    for (int i = 0; i < 30; i++) begin
      ra = {$random(seed), $random(seed)};
      rb = {$random(seed), $random(seed)} >> ($unsigned($random(seed)) % 64);
      if (rb[31:0] == 32'h0) rb = rb | 64'h1;
      run(hld_op_t'($unsigned($random(seed)) % 3), ra, rb, 1);
    end
    $display("random test done");
    for (int k = 0; k < 3; k++) run(hld_op_t'(k), ra, 64'h0, 0);
    $display("zero divisor test done");
    i_hld_pipe_model.issue(HLD_OP_DWORD_SIGNED, 64'h1234, 64'h7);
    repeat (10) @(posedge clk);
    run(HLD_OP_WORD_SIGNED, 64'h64, 64'h7, 1);
    $display("restart test done");
    prev = res;
    i_hld_pipe_model.issue(HLD_OP_NONE, 64'h9, 64'h2);
    repeat (3) @(posedge clk);
    #1;
    chk("none_busy", 0, busy);
    chk("none_res", prev.lower_result_register, res.lower_result_register);
    $display("no-op test done");
    i_hld_pipe_model.issue(HLD_OP_DWORD_UNSIGN, 64'h9, 64'h2);
    repeat (3) @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("rst2_busy", 0, busy);
    chk("rst2_res", 0, res.upper_result_register);
    run(HLD_OP_DWORD_UNSIGN, 64'h9, 64'h2, 1);
    $display("mid-run reset test done");
    wrap_up();
  end
endmodule : test_hilo_integer_divider

// ===== verilog/hld_divider.sv
/*
  Multicycle restoring divider for the two-operand upper/lower result divides.
  Assumes the issue pipeline holds result moves while busy is high and the
  request pulse is one cycle long, on the same clock.
*/
// Overview of operation
// - Signed doubleword divide treats both 64-bit operands as two's complement.
// - Unsigned doubleword divide zero-extends both 64-bit operands before dividing.
// - Signed word divide uses the low 32 bits of each operand as signed.
// - Word divide puts 32-bit quotient low, remainder high.
// - Doubleword divides put 64-bit quotient low, 64-bit remainder high.
// - No arithmetic exception is ever raised, whatever the operands.
// - Zero divisor completes normally; result value is not defined.
// - Unit is enabled only for releases older than the sixth.
// - Reads before a following divide return correct old data.
// - Quotient truncates toward zero; remainder takes dividend sign.
// - Result reads issued before completion stall until results are written.
`timescale 1ns/100ps
module hld_divider
  import hld_pkg::*;
#(
  parameter logic [3:0] RELEASE = 4'h5
) (
  input  wire logic     clk,
  input  wire logic     sys_rst,
  input  wire logic     req_valid,
  input  hld_req_t      req,
  input  wire logic     move_from_upper_result,
  input  wire logic     move_from_lower_result,
  output logic          busy,
  output logic          read_stall,
  output logic          arith_exception,
  output logic          reserved_instruction,
  output hld_res_t      res
);

  // ---------------------------------------------------------------------------
  // Datapath state
  // ---------------------------------------------------------------------------
  localparam logic IMPLEMENTED = (RELEASE <= LAST_RELEASE);

  hld_state_t   state_q, state_d;
  logic [63:0]  quo_q, quo_d;
  logic [63:0]  rem_q, rem_d;
  logic [63:0]  dvs_q, dvs_d;
  logic [6:0]   cnt_q, cnt_d;
  logic         neg_q_q, neg_q_d;
  logic         neg_r_q, neg_r_d;
  logic         word_q, word_d;
  hld_res_t     res_q, res_d;
  logic         stall_q, stall_d;
  logic         rsv_q, rsv_d;

  logic [63:0]  a_ext, b_ext, a_mag, b_mag;
  logic [64:0]  trial;
  logic [63:0]  q_fin, r_fin;
  logic         go;

  always_comb begin
    go    = req_valid && (req.op != HLD_OP_NONE) && IMPLEMENTED;
    a_ext = req.first_source_operand;
    b_ext = req.second_source_operand;
    if (req.op == HLD_OP_WORD_SIGNED) begin
      a_ext = {{WORD_W{req.first_source_operand[31]}}, req.first_source_operand[31:0]};
      b_ext = {{WORD_W{req.second_source_operand[31]}}, req.second_source_operand[31:0]};
    end
    a_mag = a_ext;
    b_mag = b_ext;
    if (req.op != HLD_OP_DWORD_UNSIGN) begin
      if (a_ext[63]) a_mag = 64'h0 - a_ext;
      if (b_ext[63]) b_mag = 64'h0 - b_ext;
    end
    trial = {rem_q, quo_q[63]} - {1'b0, dvs_q};
    q_fin = neg_q_q ? 64'h0 - quo_q : quo_q;
    r_fin = neg_r_q ? 64'h0 - rem_q : rem_q;
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    quo_d   = quo_q;
    rem_d   = rem_q;
    dvs_d   = dvs_q;
    cnt_d   = cnt_q;
    neg_q_d = neg_q_q;
    neg_r_d = neg_r_q;
    word_d  = word_q;
    rsv_d   = req_valid && (req.op != HLD_OP_NONE) && !IMPLEMENTED;
    case (state_q)
      HLD_IDLE: ;
      HLD_RUN: begin
        // Finalise one cycle after the last step
        if (cnt_q == 7'h00) begin
          state_d = HLD_IDLE;
        end else if (!trial[64]) begin
          rem_d = trial[63:0];
          quo_d = {quo_q[62:0], 1'b1};
          cnt_d = cnt_q - 7'h01;
        end else begin
          rem_d = {rem_q[62:0], quo_q[63]};
          quo_d = {quo_q[62:0], 1'b0};
          cnt_d = cnt_q - 7'h01;
        end
      end
      default: state_d = HLD_IDLE;
    endcase
    if (go) begin
      state_d = HLD_RUN;
      word_d  = (req.op == HLD_OP_WORD_SIGNED);
      neg_q_d = (req.op != HLD_OP_DWORD_UNSIGN) && (a_ext[63] ^ b_ext[63]);
      neg_r_d = (req.op != HLD_OP_DWORD_UNSIGN) && a_ext[63];
      dvs_d   = b_mag; // zero divisor just runs out the steps
      rem_d   = 64'h0;
      quo_d   = (req.op == HLD_OP_WORD_SIGNED) ? {a_mag[31:0], 32'h0} : a_mag;
      cnt_d   = (req.op == HLD_OP_WORD_SIGNED) ? STEPS_WORD : STEPS_DWORD;
    end
  end

  // Results written when counting ends and no newer divide replaced it
  logic done;
  assign done = (state_q == HLD_RUN) && (cnt_q == 7'h00) && !go;

  always_comb begin
    res_d = res_q;
    if (done) begin
      if (word_q) begin
        res_d.lower_result_register = {{WORD_W{q_fin[31]}}, q_fin[31:0]};
        res_d.upper_result_register = {{WORD_W{r_fin[31]}}, r_fin[31:0]};
      end else begin
        res_d.lower_result_register = q_fin;
        res_d.upper_result_register = r_fin;
      end
    end
    stall_d = (move_from_upper_result || move_from_lower_result)
              && (go || (state_q == HLD_RUN && !done));
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= HLD_IDLE;
      quo_q   <= ZERO_RESET;
      rem_q   <= ZERO_RESET;
      dvs_q   <= ZERO_RESET;
      cnt_q   <= 7'h00;
      neg_q_q <= 1'b0;
      neg_r_q <= 1'b0;
      word_q  <= 1'b0;
      res_q   <= '0;
      stall_q <= 1'b0;
      rsv_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      quo_q   <= quo_d;
      rem_q   <= rem_d;
      dvs_q   <= dvs_d;
      cnt_q   <= cnt_d;
      neg_q_q <= neg_q_d;
      neg_r_q <= neg_r_d;
      word_q  <= word_d;
      res_q   <= res_d; // held until a divide completes
      stall_q <= stall_d;
      rsv_q   <= rsv_d;
    end
  end

  logic busy_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) busy_q <= 1'b0;
    else         busy_q <= go || (state_q == HLD_RUN && !done);
  end

  assign busy                 = busy_q;
  assign read_stall           = stall_q;
  assign arith_exception      = 1'b0;
  assign reserved_instruction = rsv_q;
  assign res                  = res_q;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_no_exception: assert property (!arith_exception)
    else $error("divide raised an exception");
  a_busy_follows_go: assert property (go |=> busy)
    else $error("busy missing after divide issue");
  a_word_done: assert property (go && req.op == HLD_OP_WORD_SIGNED && !busy
      ##1 (!go)[*8] ##1 (!go)[*8] ##1 (!go)[*8] ##1 (!go)[*8] ##1 !go |=> !busy)
    else $error("word divide did not finish in 34 cycles");
  a_results_hold: assert property (!done |=> $stable(res))
    else $error("result registers changed without completion");
  a_stall_busy: assert property (read_stall |-> busy)
    else $error("stall without divide in flight");
  a_release_gate: assert property (IMPLEMENTED || !busy)
    else $error("divide ran on a later release");
  a_word_lower: assert property (done && word_q |=>
      res.lower_result_register[63:32] == {WORD_W{res.lower_result_register[31]}})
    else $error("word quotient not sign extended");
  a_new_discard: assert property (busy && go |=> busy)
    else $error("reissued divide dropped busy");
  a_rem_sign: assert property (done && !neg_r_q && !word_q |=>
      !res.upper_result_register[63] || dvs_q == 64'h0 || !neg_q_q)
    else $error("remainder sign differs from dividend");
  a_dword_steps: assert property ($rose(busy) && !word_q |-> cnt_q == STEPS_DWORD)
    else $error("doubleword step count wrong");
  a_unsigned_pos: assert property (go && req.op == HLD_OP_DWORD_UNSIGN
      |=> !neg_q_q && !neg_r_q)
    else $error("unsigned divide took sign");
  a_signed_neg: assert property (go && req.op == HLD_OP_DWORD_SIGNED
      |=> neg_r_q == $past(req.first_source_operand[63]))
    else $error("signed dividend sign lost");
  a_zero_div: assert property (go && b_mag == 64'h0 && IMPLEMENTED |=> busy)
    else $error("zero divisor did not start");

  c_word: cover property (go && req.op == HLD_OP_WORD_SIGNED);
  c_dword: cover property (done && !word_q);
  c_restart: cover property (busy && go);
  c_stall: cover property (read_stall);

endmodule : hld_divider

// ===== verilog/hld_pkg.sv
/*
  Shared types and constants for the upper/lower result divide unit.
  Assumes a single core clock and an issue pipeline that decodes divide operations.
*/
package hld_pkg;

  // ---------------------------------------------------------------------------
  // Widths and release gating
  // ---------------------------------------------------------------------------
  localparam int unsigned DATA_W        = 64;
  localparam int unsigned WORD_W        = 32;
  localparam int unsigned CNT_W         = 7;
  localparam logic [3:0]  LAST_RELEASE  = 4'h5;
  localparam logic [6:0]  STEPS_DWORD   = 7'h40;
  localparam logic [6:0]  STEPS_WORD    = 7'h20;
  localparam logic [63:0] ZERO_RESET    = 64'h0000_0000_0000_0000;

  // ---------------------------------------------------------------------------
  // Decoded operation
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    HLD_OP_WORD_SIGNED  = 2'h0,
    HLD_OP_DWORD_SIGNED = 2'h1,
    HLD_OP_DWORD_UNSIGN = 2'h2,
    HLD_OP_NONE         = 2'h3
  } hld_op_t;

  typedef enum logic [1:0] {
    HLD_IDLE = 2'b01,
    HLD_RUN  = 2'b10
  } hld_state_t;

  typedef struct packed {
    hld_op_t     op;
    logic [63:0] first_source_operand;
    logic [63:0] second_source_operand;
  } hld_req_t;

  typedef struct packed {
    logic [63:0] upper_result_register;
    logic [63:0] lower_result_register;
  } hld_res_t;

endpackage : hld_pkg
